// file: mdc_cfg.svh
`ifndef MDC_CFG_SVH
`define MDC_CFG_SVH

// ==========================================================================
// Register addresses and reset value.
`define MDC_ADDR_CLK_CFG 8'h45
`define MDC_ADDR_DIG_CFG 8'h46
`define MDC_ADDR_MASK 8'h47
`define MDC_REG_RESET 16'h0000

// ==========================================================================
// Field positions of the digital self-test register.
`define MDC_DIG_CRC_HI 9
`define MDC_DIG_CRC_LO 8
`define MDC_DIG_INV_A 2
`define MDC_DIG_INV_B 1
`define MDC_DIG_INV_BASE 0
`define MDC_CRC_OFF 2'h0
`define MDC_INV_OFF 3'h0
`define MDC_RB_OFF 2'h0

`endif

// file: mdc_pkg.sv
package mdc_pkg;

  // ========================================================================
  // Clock self-test register layout, most significant field first.
  typedef struct packed {
    logic [11:0] spare;
    logic main_clk_too_high_test_en;
    logic main_clk_too_low_test_en;
    logic aux_osc_watchdog_test_en;
    logic main_clk_watchdog_test_en;
  } mdc_clk_cfg_t;

  // ========================================================================
  // One general-purpose pin group: two data bits and their directions.
  // A direction bit of one means the pin is a digital output.
  typedef struct packed {
    logic [1:0] value;
    logic [1:0] direction;
  } mdc_pin_group_t;

endpackage

// file: mdc_pin_readback.sv
`timescale 1ns/1ps
`include "mdc_cfg.svh"

// Registered readback of one pin group, optionally inverted on outputs.
module mdc_pin_readback
  import mdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input mdc_pin_group_t pin_group,
  input wire logic readback_invert,
  output logic [1:0] readback_q
);

  // Only output pins are inverted, so an input pin keeps showing the true
  // pad level and the diagnostic never hides a real external signal.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readback_q <= `MDC_RB_OFF;
    end else begin
      readback_q <= pin_group.value ^
        (pin_group.direction & {2{readback_invert}});
    end
  end

endmodule

// file: mdc_diag_bank.sv
`timescale 1ns/1ps
`include "mdc_cfg.svh"

// Self-test configuration bank: clock self-test enables, digital self-test
// controls and supply fault masks, with the flags that the tests raise.
module mdc_diag_bank
  import mdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rdata_q,
  output logic reg_rd_valid_q,
  input wire logic aux_osc_watchdog_monitor_en,
  input wire logic main_clk_watchdog_monitor_en,
  output logic aux_osc_watchdog_inject_q,
  output logic main_clk_watchdog_inject_q,
  output logic main_clk_too_high_inject_q,
  output logic main_clk_too_low_inject_q,
  input wire logic aux_osc_watchdog_trip,
  input wire logic main_clk_watchdog_trip,
  input wire logic aux_osc_watchdog_flag_clr,
  input wire logic main_clk_watchdog_flag_clr,
  output logic aux_osc_watchdog_fault_flag_q,
  output logic main_clk_watchdog_fault_flag_q,
  output logic [1:0] regmap_crc_test_pattern_q,
  input wire logic regmap_crc_mismatch,
  input wire logic regmap_crc_flag_clr,
  output logic regmap_crc_fault_flag_q,
  input mdc_pin_group_t pin_group_a,
  input mdc_pin_group_t pin_group_b,
  input mdc_pin_group_t pin_group_base,
  output logic [1:0] pin_group_a_value_bits_q,
  output logic [1:0] pin_group_b_value_bits_q,
  output logic [1:0] pin_group_base_value_bits_q,
  input wire logic [15:0] supply_fault_flags,
  output logic summary_supply_fault_flag_q
);

  // ========================================================================
  // Register storage.
  mdc_clk_cfg_t clk_cfg_q; // Clock self-test register.
  logic [1:0] crc_pattern_q; // Register map CRC pattern select.
  logic [2:0] readback_inv_q; // Group A, group B, base inversion.
  logic [15:0] supply_mask_q; // One mask bit per supply fault.
  logic [15:0] dig_cfg_view; // Digital register as software reads it.
  logic wr_clk;
  logic wr_dig;
  logic wr_mask;

  assign wr_clk = reg_wr_en && (reg_addr == `MDC_ADDR_CLK_CFG);
  assign wr_dig = reg_wr_en && (reg_addr == `MDC_ADDR_DIG_CFG);
  assign wr_mask = reg_wr_en && (reg_addr == `MDC_ADDR_MASK);

  // Reserved positions are built as zero, never stored.
  always_comb begin
    dig_cfg_view = `MDC_REG_RESET;
    dig_cfg_view[`MDC_DIG_CRC_HI:`MDC_DIG_CRC_LO] = crc_pattern_q;
    dig_cfg_view[`MDC_DIG_INV_A] = readback_inv_q[2];
    dig_cfg_view[`MDC_DIG_INV_B] = readback_inv_q[1];
    dig_cfg_view[`MDC_DIG_INV_BASE] = readback_inv_q[0];
  end

  // ========================================================================
  // Clock self-test register; spare bits are plain storage so the
  // register map CRC has something to cover.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_cfg_q <= `MDC_REG_RESET;
    end else if (wr_clk) begin
      clk_cfg_q <= reg_wdata;
    end
  end

  // Digital self-test register: only the writable fields are kept.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_pattern_q <= `MDC_CRC_OFF;
      readback_inv_q <= `MDC_INV_OFF;
    end else if (wr_dig) begin
      crc_pattern_q <= reg_wdata[`MDC_DIG_CRC_HI:`MDC_DIG_CRC_LO];
      readback_inv_q <= {reg_wdata[`MDC_DIG_INV_A],
                         reg_wdata[`MDC_DIG_INV_B],
                         reg_wdata[`MDC_DIG_INV_BASE]};
    end
  end

  // Supply fault mask register, all sixteen bits writable.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_mask_q <= `MDC_REG_RESET;
    end else if (wr_mask) begin
      supply_mask_q <= reg_wdata;
    end
  end

  // ========================================================================
  // Read port: answer one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `MDC_REG_RESET;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        unique case (reg_addr)
          `MDC_ADDR_CLK_CFG: reg_rdata_q <= clk_cfg_q;
          `MDC_ADDR_DIG_CFG: reg_rdata_q <= dig_cfg_view;
          `MDC_ADDR_MASK: reg_rdata_q <= supply_mask_q;
          default: reg_rdata_q <= `MDC_REG_RESET;
        endcase
      end
    end
  end

  // ========================================================================
  // Self-test drive toward the monitors. A watchdog test is only driven
  // while its monitor is on, since a stopped monitor cannot report it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_osc_watchdog_inject_q <= 1'b0;
      main_clk_watchdog_inject_q <= 1'b0;
      main_clk_too_high_inject_q <= 1'b0;
      main_clk_too_low_inject_q <= 1'b0;
      regmap_crc_test_pattern_q <= `MDC_CRC_OFF;
    end else begin
      aux_osc_watchdog_inject_q <= clk_cfg_q.aux_osc_watchdog_test_en &&
        aux_osc_watchdog_monitor_en;
      main_clk_watchdog_inject_q <= clk_cfg_q.main_clk_watchdog_test_en &&
        main_clk_watchdog_monitor_en;
      main_clk_too_high_inject_q <=
        clk_cfg_q.main_clk_too_high_test_en;
      main_clk_too_low_inject_q <= clk_cfg_q.main_clk_too_low_test_en;
      // Any nonzero code is an equally good test pattern.
      regmap_crc_test_pattern_q <= crc_pattern_q;
    end
  end

  // ========================================================================
  // Sticky fault flags, set one cycle after the monitor trips. A trip in
  // the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_osc_watchdog_fault_flag_q <= 1'b0;
      main_clk_watchdog_fault_flag_q <= 1'b0;
      regmap_crc_fault_flag_q <= 1'b0;
    end else begin
      if (aux_osc_watchdog_trip) begin
        aux_osc_watchdog_fault_flag_q <= 1'b1;
      end else if (aux_osc_watchdog_flag_clr) begin
        aux_osc_watchdog_fault_flag_q <= 1'b0;
      end
      if (main_clk_watchdog_trip) begin
        main_clk_watchdog_fault_flag_q <= 1'b1;
      end else if (main_clk_watchdog_flag_clr) begin
        main_clk_watchdog_fault_flag_q <= 1'b0;
      end
      if (regmap_crc_mismatch) begin
        regmap_crc_fault_flag_q <= 1'b1;
      end else if (regmap_crc_flag_clr) begin
        regmap_crc_fault_flag_q <= 1'b0;
      end
    end
  end

  // Summary supply fault: masked flags are dropped before the OR.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_supply_fault_flag_q <= 1'b0;
    end else begin
      summary_supply_fault_flag_q <=
        |(supply_fault_flags & ~supply_mask_q);
    end
  end

  // ========================================================================
  // Pin readback, one instance per group.
  mdc_pin_readback u_rb_a (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_group(pin_group_a),
    .readback_invert(readback_inv_q[2]),
    .readback_q(pin_group_a_value_bits_q)
  );

  mdc_pin_readback u_rb_b (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_group(pin_group_b),
    .readback_invert(readback_inv_q[1]),
    .readback_q(pin_group_b_value_bits_q)
  );

  mdc_pin_readback u_rb_base (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_group(pin_group_base),
    .readback_invert(readback_inv_q[0]),
    .readback_q(pin_group_base_value_bits_q)
  );

  // ========================================================================
  // Assertions.
  property p_spare_rw;
    @(posedge core_clk) disable iff (!rst_n)
    wr_clk ##1 (reg_rd_en && reg_addr == `MDC_ADDR_CLK_CFG && !reg_wr_en)
      |=> reg_rdata_q[15:4] == $past(reg_wdata[15:4], 2);
  endproperty
  a_spare_rw: assert property (p_spare_rw)
    else $error("Spare bits did not read back as written.");

  property p_aux_test;
    @(posedge core_clk) disable iff (!rst_n)
    aux_osc_watchdog_inject_q |->
      $past(clk_cfg_q[1]) && $past(aux_osc_watchdog_monitor_en);
  endproperty
  a_aux_test: assert property (p_aux_test)
    else $error("Aux watchdog test driven without enables.");

  property p_aux_flag;
    @(posedge core_clk) disable iff (!rst_n)
    aux_osc_watchdog_trip |=> aux_osc_watchdog_fault_flag_q;
  endproperty
  a_aux_flag: assert property (p_aux_flag)
    else $error("Aux watchdog flag not set after trip.");

  property p_main_test;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_clk && reg_wdata[0]) ##1 main_clk_watchdog_monitor_en[*2]
      |-> main_clk_watchdog_inject_q;
  endproperty
  a_main_test: assert property (p_main_test)
    else $error("Main watchdog test not driven.");

  property p_crc_off;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_dig && reg_wdata[9:8] == `MDC_CRC_OFF) ##1 !wr_dig
      |=> regmap_crc_test_pattern_q == `MDC_CRC_OFF;
  endproperty
  a_crc_off: assert property (p_crc_off)
    else $error("CRC pattern not disabled by code zero.");

  property p_crc_flag;
    @(posedge core_clk) disable iff (!rst_n)
    (regmap_crc_mismatch && regmap_crc_flag_clr) |=>
      regmap_crc_fault_flag_q [*1];
  endproperty
  a_crc_flag: assert property (p_crc_flag)
    else $error("CRC flag lost to a simultaneous clear.");

  property p_inv_a;
    @(posedge core_clk) disable iff (!rst_n)
    readback_inv_q[2] && pin_group_a.direction == 2'h3 |=>
      pin_group_a_value_bits_q == ~$past(pin_group_a.value);
  endproperty
  a_inv_a: assert property (p_inv_a)
    else $error("Group A output readback not inverted.");

  property p_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == `MDC_ADDR_DIG_CFG |=>
      reg_rdata_q[15:10] == 6'h00 && reg_rdata_q[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved digital bits read nonzero.");

  property p_mask;
    @(posedge core_clk) disable iff (!rst_n)
    (supply_fault_flags & ~supply_mask_q) == 16'h0000 |=>
      !summary_supply_fault_flag_q;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked supply fault reached the summary.");

  property p_input_pin;
    @(posedge core_clk) disable iff (!rst_n)
    pin_group_b.direction == 2'h0 |=>
      pin_group_b_value_bits_q == $past(pin_group_b.value);
  endproperty
  a_input_pin: assert property (p_input_pin)
    else $error("Input pin readback was inverted.");

  c_aux_test: cover property (@(posedge core_clk) disable iff (!rst_n)
    aux_osc_watchdog_inject_q ##[1:20] aux_osc_watchdog_fault_flag_q);
  c_crc_pat3: cover property (@(posedge core_clk) disable iff (!rst_n)
    regmap_crc_test_pattern_q == 2'h3);
  c_mask_hit: cover property (@(posedge core_clk) disable iff (!rst_n)
    (supply_fault_flags != 16'h0000) && !summary_supply_fault_flag_q);

endmodule

// file: mdc_host_model.sv
`timescale 1ns/1ps

// ==========================================================================
// Host controller model on the register port.
// Each request is launched just after an edge and held through the next
// edge. The strobes stay high until the next request or idle. An idle cycle
// inverts the address and data lines, so that a stale value is never
// mistaken for a fresh one.
module mdc_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [15:0] reg_wdata,
  output logic reg_rd_en
);
  // The bus starts quiet, with both strobes low.
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd_en = 1'b0;
  end

  // Drive one word, either a write or a read, through the next edge; it stays on the bus until the next call.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [15:0] d);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr = a;
    reg_wdata = wr ? d : ~reg_wdata;
    @(posedge core_clk);
    #1;
  endtask

  // Release the bus for one cycle.
  task automatic idle();
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(posedge core_clk);
    #1;
  endtask
endmodule

// file: monitor_diag_config_bank_tb.sv
`timescale 1ns/1ps
`include "mdc_cfg.svh"

`define CHK(nm, e, a) begin checked++; \
  if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, a); end end

// ==========================================================================
// Self-checking bench. Reads leave their expected word in a queue, and a
// watcher compares that word against the returned data.
module monitor_diag_config_bank_tb
  import mdc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr_en, reg_rd_en, reg_rd_valid_q, summary;
  logic [15:0] reg_wdata, reg_rdata_q, faults, v, m;
  // The watcher keeps its own word, so it never clobbers the main
  // sequence's copy of a value that is still to be read back.
  logic [15:0] exp_word;
  logic [1:0] mon_en; // Bit 1 is the aux monitor, bit 0 is main.
  logic [2:0] trip, clr, flag; // Aux, main, CRC.
  logic [3:0] inj; // High, low, aux, main.
  logic [1:0] pat;
  mdc_pin_group_t grp [3]; // Group a, b, base.
  logic [1:0] rb [3];
  logic [15:0] exp_q [$];
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  mdc_host_model mdc_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en));

  mdc_diag_bank mdc_diag_bank_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
    .reg_rd_valid_q(reg_rd_valid_q),
    .aux_osc_watchdog_monitor_en(mon_en[1]),
    .main_clk_watchdog_monitor_en(mon_en[0]),
    .aux_osc_watchdog_inject_q(inj[1]), .main_clk_watchdog_inject_q(inj[0]),
    .main_clk_too_high_inject_q(inj[3]), .main_clk_too_low_inject_q(inj[2]),
    .aux_osc_watchdog_trip(trip[2]), .main_clk_watchdog_trip(trip[1]),
    .aux_osc_watchdog_flag_clr(clr[2]), .main_clk_watchdog_flag_clr(clr[1]),
    .aux_osc_watchdog_fault_flag_q(flag[2]),
    .main_clk_watchdog_fault_flag_q(flag[1]),
    .regmap_crc_test_pattern_q(pat), .regmap_crc_mismatch(trip[0]),
    .regmap_crc_flag_clr(clr[0]), .regmap_crc_fault_flag_q(flag[0]),
    .pin_group_a(grp[0]), .pin_group_b(grp[1]), .pin_group_base(grp[2]),
    .pin_group_a_value_bits_q(rb[0]), .pin_group_b_value_bits_q(rb[1]),
    .pin_group_base_value_bits_q(rb[2]), .supply_fault_flags(faults),
    .summary_supply_fault_flag_q(summary));

  // Free-running clock at 25 MHz.
  always #20 core_clk = ~core_clk;

  // A hang is cut short well beyond the hundred or so cycles of the run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  // Read data is judged mid-cycle, where the registered answer has settled.
  always @(negedge core_clk) begin
    if (reg_rd_valid_q === 1'b1) begin
      exp_word = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
      `CHK("read_data", exp_word, reg_rdata_q)
    end
  end

  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bus helpers: a read notes its expected word before it is launched.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    mdc_host_model_i.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    mdc_host_model_i.xfer(1'b0, a, 16'h0000);
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    mon_en = 2'h0;
    trip = 3'h0;
    clr = 3'h0;
    faults = 16'h0000;
    for (int k = 0; k < 3; k++) grp[k] = '0;
    void'($urandom(32'h05C2));
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    rd(`MDC_ADDR_CLK_CFG, `MDC_REG_RESET);
    rd(`MDC_ADDR_DIG_CFG, `MDC_REG_RESET);
    rd(`MDC_ADDR_MASK, `MDC_REG_RESET);
    // Random words; the clock and digital words are read back in the very next cycle.
    v = 16'($urandom());
    wr(`MDC_ADDR_CLK_CFG, v);
    rd(`MDC_ADDR_CLK_CFG, v);
    m = 16'($urandom());
    wr(`MDC_ADDR_DIG_CFG, m);
    rd(`MDC_ADDR_DIG_CFG, m & 16'h0307);
    wr(`MDC_ADDR_MASK, ~v);
    wr(8'h48, 16'hFFFF);
    rd(8'h44, 16'h0000);
    rd(`MDC_ADDR_MASK, ~v);
    rd(`MDC_ADDR_CLK_CFG, v);
    // Watchdog injects are gated by their monitor enables. Both monitors
    // are on while the enables are written, so the watchdog inject is
    // seen to follow a fresh write.
    mon_en = 2'h3;
    wr(`MDC_ADDR_CLK_CFG, 16'h000F);
    wr(`MDC_ADDR_DIG_CFG, 16'h0100);
    mdc_host_model_i.idle();
    for (int i = 0; i < 4; i++) begin
      mon_en = i[1:0];
      step();
      `CHK("inject", {2'b11, i[1:0]}, inj)
    end
    // Each flag sets one cycle after its trip and holds until cleared.
    for (int i = 1; i < 8; i++) begin
      trip = i[2:0];
      step();
      trip = 3'h0;
      `CHK("flag_set", i[2:0], flag)
      step();
      clr = 3'h7;
      `CHK("flag_hold", i[2:0], flag)
      step();
      clr = 3'h0;
      `CHK("flag_clr", 3'h0, flag)
    end
    trip = 3'h7;
    clr = 3'h7;
    step();
    trip = 3'h0;
    clr = 3'h0;
    `CHK("flag_set_wins", 3'h7, flag)
    // A cleared clock register drops every inject.
    wr(`MDC_ADDR_CLK_CFG, 16'h0000);
    mdc_host_model_i.idle();
    `CHK("inject_off", 4'h0, inj)
    // Every pattern code, including the disabled one.
    for (int p = 0; p < 4; p++) begin
      wr(`MDC_ADDR_DIG_CFG, {6'h00, p[1:0], 8'h00});
      mdc_host_model_i.idle();
      `CHK("crc_pattern", p[1:0], pat)
    end
    // Readback inversion applies only to pins driven as outputs.
    for (int i = 0; i < 16; i++) begin
      wr(`MDC_ADDR_DIG_CFG, {13'h0000, i[2:0]});
      for (int k = 0; k < 3; k++) grp[k] = 4'($urandom());
      mdc_host_model_i.idle();
      for (int k = 0; k < 3; k++) begin
        m = {14'h0000, grp[k].value ^ (grp[k].direction & {2{i[2-k]}})};
        `CHK("readback", m[1:0], rb[k])
      end
    end
    // Masked faults stay out of the summary; the first pass masks none of the raised faults.
    for (int i = 0; i < 8; i++) begin
      faults = 16'($urandom());
      m = (i == 0) ? ~faults : 16'($urandom());
      wr(`MDC_ADDR_MASK, m);
      mdc_host_model_i.idle();
      `CHK("summary", |(faults & ~m), summary)
    end
    step();
    step();
    `CHK("read_queue", 0, exp_q.size())
    conclude();
  end
endmodule
